// >>> verilog/vpi_pkg.sv
// package: constants and types of the interrupt controller
`default_nettype none

package vpi_pkg;

    // ****************************************************************
    // register map (byte addresses)
    // ****************************************************************
    localparam logic [7:0] OFF_CH9_PRIO    = 8'h00;
    localparam logic [7:0] OFF_CTRL_STATUS = 8'h04;
    localparam logic [7:0] OFF_INTCTRL1    = 8'h08;
    localparam logic [7:0] OFF_FLAGS       = 8'h0c;
    localparam logic [7:0] OFF_ENABLES     = 8'h10;
    localparam logic [7:0] OFF_LOW_STATUS  = 8'h14;
    localparam logic [7:0] OFF_DISABLE_CNT = 8'h18;

    // ****************************************************************
    // field positions
    // ****************************************************************
    localparam int CAP9_PRIO_LSB   = 4;
    localparam int CMP9_PRIO_LSB   = 0;
    localparam int UNACKED_BIT     = 15;
    localparam int CAPTURE_BIT     = 13;
    localparam int LEVEL_LSB       = 8;
    localparam int NEST_DIS_BIT    = 15;
    localparam int IPL_LSB         = 5;

    // ****************************************************************
    // reset values and sizes
    // ****************************************************************
    localparam logic [2:0]  PRIO_RESET      = 3'h4;
    localparam logic [15:0] DISABLE_CNT_RST = 16'h0010;
    localparam logic [3:0]  USER_MAX_LEVEL  = 4'h7;
    localparam logic [3:0]  TIMED_MAX_LEVEL = 4'h6;
    localparam logic [7:0]  VECTOR_BASE     = 8'h08;
    localparam int          NUM_SRC         = 2;
    localparam int          NUM_TRAP        = 4;
    localparam int          STACK_DEPTH     = 4;

    // vector numbers of the sources: arbitrary assignment
    localparam logic [7:0] VEC_CAP9  = 8'h60;
    localparam logic [7:0] VEC_CMP9  = 8'h61;
    localparam logic [7:0] VEC_TRAP0 = 8'h01;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ****************************************************************
    // types
    // ****************************************************************
    typedef struct packed {
        logic       valid;
        logic [3:0] level;
        logic [7:0] vector;
    } vpi_request_t;

    typedef struct packed {
        logic [4:0] low_bits;
        logic [3:0] level;
    } vpi_frame_t;

endpackage : vpi_pkg

`default_nettype wire

// >>> verilog/vpi_ctrl.sv
// module: vectored priority interrupt controller
`timescale 1ns/1ps
`default_nettype none

// Contract
// - capture-9 priority is three bits at 6-4; 000 disables, 111 highest.
// - compare-9 priority is three bits at 2-0, same encoding.
// - every user priority field resets to level 4.
// - priority register bits 15-7 and 3 read zero.
// - status bit 15 shows a pending request held off by CPU level.
// - capture-mode bit 13 picks highest pending or last acknowledged vector.
// - status bits 11-8 report the current CPU priority level.
// - status bits 6-0 hold vector number minus eight.
// - source flag stays set until software clears it; request repeats.
// - trap flags live in first control register; trap repeats until cleared.
// - CPU level masks only user levels up to 7; traps never masked.
// - level 7 in low status byte blocks all user sources.
// - timed disable blocks levels 1-6, level 7 still interrupts.
// - nesting-disable at bit 15 of first control register stops nesting.
// - return restores saved low status byte and previous CPU level.
// - each source has a flag and enable; only enabled sources interrupt.
module vpi_ctrl (
    // clock and reset
    input  wire logic                  aclk,
    input  wire logic                  aresetn,
    // axi4-lite write address and data
    input  wire logic [7:0]            s_axi_awaddr,
    input  wire logic                  s_axi_awvalid,
    output var  logic                  s_axi_awready,
    input  wire logic [31:0]           s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    input  wire logic                  s_axi_wvalid,
    output var  logic                  s_axi_wready,
    // axi4-lite write response
    output var  logic [1:0]            s_axi_bresp,
    output var  logic                  s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    // axi4-lite read
    input  wire logic [7:0]            s_axi_araddr,
    input  wire logic                  s_axi_arvalid,
    output var  logic                  s_axi_arready,
    output var  logic [31:0]           s_axi_rdata,
    output var  logic [1:0]            s_axi_rresp,
    output var  logic                  s_axi_rvalid,
    input  wire logic                  s_axi_rready,
    // source and trap events, one-cycle pulses
    input  wire logic [1:0]            src_event,
    input  wire logic [3:0]            trap_event,
    // processor core
    input  wire logic                  cpu_ack,
    input  wire logic                  cpu_return,
    input  wire logic                  cpu_timed_disable,
    output var  vpi_pkg::vpi_request_t cpu_request,
    // level interrupt of flag and enable registers
    output var  logic                  irq
);

    // ****************************************************************
    // state
    // ****************************************************************
    logic [2:0]  cap9_priority;
    logic [2:0]  cmp9_priority;
    logic        vector_capture_mode;
    logic        nesting_disable;
    logic [3:0]  trap_flags;
    logic [1:0]  flag_regs;
    logic [1:0]  enable_regs;
    logic [3:0]  cur_level;
    logic [4:0]  low_status_bits;
    logic [15:0] disable_cnt;
    logic [15:0] disable_timer;
    logic [7:0]  last_vector;
    vpi_pkg::vpi_frame_t stack [vpi_pkg::STACK_DEPTH];
    logic [2:0]  depth;

    logic        aw_held;
    logic        w_held;
    logic [7:0]  aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;

    // ****************************************************************
    // helpers
    // ****************************************************************
    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] data,
                                            input logic [3:0] strb);
        merge16 = {strb[1] ? data[15:8] : old[15:8], strb[0] ? data[7:0] : old[7:0]};
    endfunction

    // sticky flag: a new event wins over a same-cycle clear
    function automatic logic [3:0] sticky(input logic [3:0] old, input logic [3:0] set,
                                          input logic [3:0] clr);
        sticky = (old & ~clr) | set;
    endfunction

    // ****************************************************************
    // arbitration
    // ****************************************************************
    wire        timed_active = (disable_timer != 16'h0000);
    wire        in_service   = (depth != 3'h0);
    wire [3:0]  cap9_level   = {1'b0, cap9_priority};
    wire [3:0]  cmp9_level   = {1'b0, cmp9_priority};
    // a level-0 field disables its source
    wire        cap9_live    = flag_regs[0] & enable_regs[0] & (cap9_priority != 3'h0);
    wire        cmp9_live    = flag_regs[1] & enable_regs[1] & (cmp9_priority != 3'h0);
    // timed disable hides levels 1-6 only
    wire        cap9_timed   = timed_active & (cap9_level <= vpi_pkg::TIMED_MAX_LEVEL);
    wire        cmp9_timed   = timed_active & (cmp9_level <= vpi_pkg::TIMED_MAX_LEVEL);
    wire        nest_block   = nesting_disable & in_service;
    wire        cap9_ok      = cap9_live & ~cap9_timed & ~nest_block;
    wire        cmp9_ok      = cmp9_live & ~cmp9_timed & ~nest_block;

    logic [3:0] best_level;
    logic [7:0] best_vector;
    logic       best_valid;
    always_comb begin
        best_level  = 4'h0;
        best_vector = 8'h00;
        best_valid  = 1'b0;
        // traps sit at levels 15 down to 12 and ignore every mask
        for (int i = vpi_pkg::NUM_TRAP - 1; i >= 0; i--) begin
            if (trap_flags[i]) begin
                best_level  = 4'hf - 4'(i);
                best_vector = vpi_pkg::VEC_TRAP0 + 8'(i);
                best_valid  = 1'b1;
            end
        end
        if (!best_valid && cap9_ok && (!cmp9_ok || cap9_level >= cmp9_level)) begin
            best_level  = cap9_level;
            best_vector = vpi_pkg::VEC_CAP9;
            best_valid  = 1'b1;
        end else if (!best_valid && cmp9_ok) begin
            best_level  = cmp9_level;
            best_vector = vpi_pkg::VEC_CMP9;
            best_valid  = 1'b1;
        end
    end

    // cpu level at 7 masks all user sources, traps still exceed it
    wire        beats_cpu    = best_valid & (best_level > cur_level);
    wire        held_off     = best_valid & ~beats_cpu;
    wire        take_ack     = cpu_ack & cpu_request.valid;
    wire        do_push      = take_ack & (depth != 3'(vpi_pkg::STACK_DEPTH));
    wire        do_pop       = cpu_return & in_service & ~take_ack;
    wire [2:0]  top_idx      = depth - 3'h1;
    wire [7:0]  shown_vector = vector_capture_mode ? best_vector : last_vector;
    wire [6:0]  vec_field    = 7'(shown_vector - vpi_pkg::VECTOR_BASE);

    // ****************************************************************
    // register read mux
    // ****************************************************************
    wire [15:0] rd_prio   = {9'h000, cap9_priority, 1'b0, cmp9_priority};
    wire [15:0] rd_status = {held_off, 1'b0, vector_capture_mode, 1'b0, cur_level,
                             1'b0, vec_field};
    wire [15:0] rd_ctrl1  = {nesting_disable, 11'h000, trap_flags};
    wire [15:0] rd_low    = {8'h00, cur_level[2:0], low_status_bits};
    // every aligned word up to the last offset is mapped
    wire        rd_hit    = (s_axi_araddr[1:0] == 2'h0)
                          & (s_axi_araddr <= vpi_pkg::OFF_DISABLE_CNT);
    wire [15:0] rd_word   = (s_axi_araddr == vpi_pkg::OFF_CH9_PRIO)    ? rd_prio :
                            (s_axi_araddr == vpi_pkg::OFF_CTRL_STATUS) ? rd_status :
                            (s_axi_araddr == vpi_pkg::OFF_INTCTRL1)    ? rd_ctrl1 :
                            (s_axi_araddr == vpi_pkg::OFF_FLAGS)       ? {14'h0000, flag_regs} :
                            (s_axi_araddr == vpi_pkg::OFF_ENABLES)     ? {14'h0000, enable_regs} :
                            (s_axi_araddr == vpi_pkg::OFF_LOW_STATUS)  ? rd_low :
                            (s_axi_araddr == vpi_pkg::OFF_DISABLE_CNT) ? disable_cnt : 16'h0000;
    wire        rd_take   = s_axi_arvalid & s_axi_arready;

    // ****************************************************************
    // write decode
    // ****************************************************************
    wire        wr_go     = aw_held & w_held & ~s_axi_bvalid;
    wire        wr_prio   = wr_go & (aw_addr == vpi_pkg::OFF_CH9_PRIO);
    wire        wr_status = wr_go & (aw_addr == vpi_pkg::OFF_CTRL_STATUS);
    wire        wr_ctrl1  = wr_go & (aw_addr == vpi_pkg::OFF_INTCTRL1);
    wire        wr_flags  = wr_go & (aw_addr == vpi_pkg::OFF_FLAGS);
    wire        wr_enab   = wr_go & (aw_addr == vpi_pkg::OFF_ENABLES);
    wire        wr_low    = wr_go & (aw_addr == vpi_pkg::OFF_LOW_STATUS);
    wire        wr_dcnt   = wr_go & (aw_addr == vpi_pkg::OFF_DISABLE_CNT);
    wire        wr_hit    = wr_prio | wr_status | wr_ctrl1 | wr_flags | wr_enab | wr_low | wr_dcnt;
    wire [15:0] m_prio    = merge16(rd_prio, w_data, w_strb);
    wire [15:0] m_status  = merge16(rd_status, w_data, w_strb);
    wire [15:0] m_ctrl1   = merge16(rd_ctrl1, w_data, w_strb);
    wire [15:0] m_low     = merge16(rd_low, w_data, w_strb);
    wire [15:0] m_dcnt    = merge16(disable_cnt, w_data, w_strb);
    // write-one-to-clear, only on byte lanes that are enabled
    wire [3:0]  trap_clr  = (wr_ctrl1 & w_strb[0]) ? w_data[3:0] : 4'h0;
    wire [1:0]  flag_clr  = (wr_flags & w_strb[0]) ? w_data[1:0] : 2'h0;
    wire [3:0]  next_trap = sticky(trap_flags, trap_event, trap_clr);
    wire [3:0]  next_flag = sticky({2'h0, flag_regs}, {2'h0, src_event}, {2'h0, flag_clr});

    // ****************************************************************
    // axi4-lite handshake
    // ****************************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            aw_held       <= 1'b0;
            w_held        <= 1'b0;
            aw_addr       <= 8'h00;
            w_data        <= 32'h0000_0000;
            w_strb        <= 4'h0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= vpi_pkg::RESP_OKAY;
        end else begin
            s_axi_awready <= ~aw_held & ~(s_axi_awvalid & s_axi_awready);
            s_axi_wready  <= ~w_held & ~(s_axi_wvalid & s_axi_wready);
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end else if (wr_go) begin
                aw_held <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end else if (wr_go) begin
                w_held <= 1'b0;
            end
            if (wr_go) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_hit ? vpi_pkg::RESP_OKAY : vpi_pkg::RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= vpi_pkg::RESP_OKAY;
        end else begin
            s_axi_arready <= ~s_axi_rvalid & ~rd_take;
            if (rd_take) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= {16'h0000, rd_word};
                s_axi_rresp  <= rd_hit ? vpi_pkg::RESP_OKAY : vpi_pkg::RESP_SLVERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // configuration registers
    // ****************************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cap9_priority       <= vpi_pkg::PRIO_RESET;
            cmp9_priority       <= vpi_pkg::PRIO_RESET;
            vector_capture_mode <= 1'b0;
            nesting_disable     <= 1'b0;
            enable_regs         <= 2'h0;
            disable_cnt         <= vpi_pkg::DISABLE_CNT_RST;
        end else begin
            if (wr_prio) begin
                cap9_priority <= m_prio[vpi_pkg::CAP9_PRIO_LSB +: 3];
                cmp9_priority <= m_prio[vpi_pkg::CMP9_PRIO_LSB +: 3];
            end
            if (wr_status) begin
                vector_capture_mode <= m_status[vpi_pkg::CAPTURE_BIT];
            end
            if (wr_ctrl1) begin
                nesting_disable <= m_ctrl1[vpi_pkg::NEST_DIS_BIT];
            end
            if (wr_enab && w_strb[0]) begin
                enable_regs <= w_data[1:0];
            end
            if (wr_dcnt) begin
                disable_cnt <= m_dcnt;
            end
        end
    end

    // ****************************************************************
    // flags, timed disable, cpu level and return stack
    // ****************************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            trap_flags    <= 4'h0;
            flag_regs     <= 2'h0;
            disable_timer <= 16'h0000;
        end else begin
            trap_flags <= next_trap;
            flag_regs  <= next_flag[1:0];
            if (cpu_timed_disable) begin
                disable_timer <= disable_cnt;
            end else if (timed_active) begin
                disable_timer <= disable_timer - 16'h0001;
            end
        end
    end

    // a full stack drops the frame
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cur_level       <= 4'h0;
            low_status_bits <= 5'h00;
            depth           <= 3'h0;
            last_vector     <= vpi_pkg::VECTOR_BASE;
            for (int i = 0; i < vpi_pkg::STACK_DEPTH; i++) begin
                stack[i] <= '0;
            end
        end else if (take_ack) begin
            cur_level   <= best_level;
            last_vector <= best_vector;
            if (do_push) begin
                stack[depth[1:0]] <= '{low_bits: low_status_bits, level: cur_level};
                depth             <= depth + 3'h1;
            end
        end else if (do_pop) begin
            cur_level       <= stack[top_idx[1:0]].level;
            low_status_bits <= stack[top_idx[1:0]].low_bits;
            depth           <= top_idx;
        end else if (wr_low) begin
            // level 7 shuts out every user source
            cur_level       <= {1'b0, m_low[vpi_pkg::IPL_LSB +: 3]};
            low_status_bits <= m_low[4:0];
        end
    end

    // ****************************************************************
    // outputs to the core
    // ****************************************************************
    // a flag left set re-raises its request
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cpu_request <= '0;
            irq         <= 1'b0;
        end else begin
            cpu_request.valid  <= beats_cpu & ~take_ack & ~cpu_return;
            cpu_request.level  <= best_level;
            cpu_request.vector <= best_vector;
            irq                <= |(next_flag[1:0] & enable_regs);
        end
    end

endmodule // vpi_ctrl

`default_nettype wire

// >>> dv/vpi_ctrl_asserts.sv
// checker: assertions on the controller ports
`timescale 1ns/1ps
`default_nettype none
module vpi_ctrl_asserts (
    // clock and reset
    input wire logic                  aclk,
    input wire logic                  aresetn,
    // register bus
    input wire logic                  s_axi_awvalid,
    input wire logic                  s_axi_awready,
    input wire logic                  s_axi_wvalid,
    input wire logic                  s_axi_wready,
    input wire logic                  s_axi_bvalid,
    input wire logic [7:0]            s_axi_araddr,
    input wire logic                  s_axi_arvalid,
    input wire logic                  s_axi_arready,
    input wire logic [31:0]           s_axi_rdata,
    input wire logic                  s_axi_rvalid,
    input wire logic                  s_axi_rready,
    // core link
    input wire logic                  cpu_ack,
    input wire logic                  cpu_timed_disable,
    input wire logic [3:0]            trap_event,
    input wire vpi_pkg::vpi_request_t cpu_request
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // address of the read in flight
    logic [7:0] rd_addr;
    always_ff @(posedge aclk) begin
        if (!aresetn)
            rd_addr <= 8'h00;
        else if (s_axi_arvalid && s_axi_arready)
            rd_addr <= s_axi_araddr;
    end
    sequence s_wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    sequence s_quiet_user;
        !(cpu_request.valid && cpu_request.level inside {[4'h1:4'h6]});
    endsequence
    AST_B_LATENCY: assert property (s_wr_taken |-> ##[2:3] s_axi_bvalid)
        else $error("write response missing");
    AST_R_LATENCY: assert property (s_rd_taken |=> s_axi_rvalid)
        else $error("read data missing");
    AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    AST_PRIO_RSVD: assert property (s_axi_rvalid && rd_addr == vpi_pkg::OFF_CH9_PRIO |->
        s_axi_rdata[31:7] == 25'h0 && !s_axi_rdata[3]) else $error("priority reserved bits set");
    AST_STAT_RSVD: assert property (s_axi_rvalid && rd_addr == vpi_pkg::OFF_CTRL_STATUS |->
        !s_axi_rdata[14] && !s_axi_rdata[12] && !s_axi_rdata[7]) else $error("status reserved bits set");
    AST_ACK_DROPS: assert property (cpu_ack && cpu_request.valid |=> !cpu_request.valid)
        else $error("request stays after ack");
    AST_TRAP: assert property (trap_event[0] && !cpu_request.valid && !cpu_ack |->
        ##[1:3] (cpu_request.valid && cpu_request.level == 4'hf)) else $error("trap not requested");
    AST_TIMED: assert property (cpu_timed_disable |-> ##2 s_quiet_user [*8])
        else $error("user level passed timed disable");
endmodule // vpi_ctrl_asserts
bind vpi_ctrl vpi_ctrl_asserts u_vpi_chk (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .cpu_ack(cpu_ack), .cpu_timed_disable(cpu_timed_disable),
    .trap_event(trap_event), .cpu_request(cpu_request));
`default_nettype wire

// >>> dv/vpi_core_model.sv
// partner: core that acks requests after a set wait
`timescale 1ns/1ps
`default_nettype none
module vpi_core_model (
    // clock and reset
    input wire logic                  aclk,
    input wire logic                  aresetn,
    // bench controls
    input wire logic                  ack_on,
    input wire logic [3:0]            ack_wait,
    // controller link
    input wire vpi_pkg::vpi_request_t cpu_request,
    output var logic                  cpu_ack
);
    logic [3:0] wait_cnt;
    // one pulse per request; the ack edge drops valid, so no double take
    always_ff @(posedge aclk) begin
        if (!aresetn || !ack_on || !cpu_request.valid || cpu_ack) begin
            cpu_ack  <= 1'b0;
            wait_cnt <= 4'h0;
        end else if (wait_cnt == ack_wait) begin
            cpu_ack <= 1'b1;
        end else begin
            wait_cnt <= wait_cnt + 4'h1;
        end
    end
endmodule // vpi_core_model
`default_nettype wire

// >>> dv/testbench.sv
// testbench of the interrupt controller
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, ack_on;
    logic awready, wready, bvalid, arready, rvalid, irq, cpu_ack, cpu_return, cpu_timed_disable;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [1:0]  bresp, rresp, src_event;
    logic [3:0]  trap_event, ack_wait;
    vpi_pkg::vpi_request_t cpu_request;
    int err_total, total_checks;
    localparam logic [7:0] STAT = vpi_pkg::OFF_CTRL_STATUS, PRIO = vpi_pkg::OFF_CH9_PRIO;
    vpi_ctrl DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .src_event(src_event),
        .trap_event(trap_event), .cpu_ack(cpu_ack), .cpu_return(cpu_return),
        .cpu_timed_disable(cpu_timed_disable), .cpu_request(cpu_request), .irq(irq));
    vpi_core_model u_core (.aclk(aclk), .aresetn(aresetn), .ack_on(ack_on), .ack_wait(ack_wait),
        .cpu_request(cpu_request), .cpu_ack(cpu_ack));
    initial begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end
    task automatic tally_and_finish;
        if (err_total == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        int n;
        n = 0;
        @(posedge aclk);
        {awaddr, wdata, awvalid, wvalid, bready} <= {a, 16'h0000, d, 3'b111};
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            n++;
        end while (!bvalid && n < 50);
        bready <= 1'b0;
        chk(32'(bresp), 32'(vpi_pkg::RESP_OKAY));
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] exp);
        int n;
        n = 0;
        @(posedge aclk);
        {araddr, arvalid, rready} <= {a, 2'b11};
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            n++;
        end while (!rvalid && n < 50);
        rready <= 1'b0;
        chk(rdata, {16'h0000, exp});
        chk(32'(rresp), 32'(a[6] ? vpi_pkg::RESP_SLVERR : vpi_pkg::RESP_OKAY));
    endtask
    task automatic pulse(input logic [1:0] s, input logic [3:0] t, input logic r, input logic d);
        @(posedge aclk);
        {src_event, trap_event, cpu_return, cpu_timed_disable} <= {s, t, r, d};
        @(posedge aclk);
        {src_event, trap_event, cpu_return, cpu_timed_disable} <= 8'h00;
        repeat (3) @(posedge aclk);
    endtask
    task automatic creq(input logic v, input logic [3:0] l, input logic [7:0] vec);
        if (v)
            chk({19'h0, cpu_request}, {19'h0, v, l, vec});
        else
            chk(32'(cpu_request.valid), 32'h0);
    endtask
    task automatic test_regs;
        rd(PRIO, 16'h0044);
        rd(STAT, 16'h0000);
        wr(PRIO, 16'hffff);
        rd(PRIO, 16'h0077);
        rd(8'h40, 16'h0000);
        wr(PRIO, 16'h0052);
    endtask
    task automatic test_service;
        pulse(2'b01, 4'h0, 1'b0, 1'b0);
        chk(32'(irq), 32'h0);
        creq(1'b0, 4'h0, 8'h00);
        wr(vpi_pkg::OFF_ENABLES, 16'h0001);
        repeat (2) @(posedge aclk);
        chk(32'(irq), 32'h1);
        creq(1'b1, 4'h5, 8'h60);
        ack_on <= 1'b1;
        repeat (8) @(posedge aclk);
        rd(STAT, 16'h8558);
        wr(STAT, 16'h2000);
        rd(STAT, 16'ha558);
        pulse(2'b00, 4'h0, 1'b1, 1'b0);
        repeat (5) @(posedge aclk);
        rd(STAT, 16'ha558);
        ack_on <= 1'b0;
        wr(vpi_pkg::OFF_FLAGS, 16'h0001);
        wr(STAT, 16'h0000);
        pulse(2'b00, 4'h0, 1'b1, 1'b0);
        rd(STAT, 16'h0058);
    endtask
    task automatic test_mask;
        wr(vpi_pkg::OFF_LOW_STATUS, 16'h00e0);
        pulse(2'b01, 4'h0, 1'b0, 1'b0);
        creq(1'b0, 4'h0, 8'h00);
        pulse(2'b00, 4'h1, 1'b0, 1'b0);
        creq(1'b1, 4'hf, 8'h01);
        rd(vpi_pkg::OFF_INTCTRL1, 16'h0001);
        wr(vpi_pkg::OFF_INTCTRL1, 16'h0001);
        rd(vpi_pkg::OFF_INTCTRL1, 16'h0000);
        rd(STAT, 16'h8758);
        wr(vpi_pkg::OFF_FLAGS, 16'h0001);
        wr(vpi_pkg::OFF_LOW_STATUS, 16'h0000);
    endtask
    task automatic test_timed;
        wr(PRIO, 16'h0076);
        wr(vpi_pkg::OFF_ENABLES, 16'h0003);
        pulse(2'b00, 4'h0, 1'b0, 1'b1);
        pulse(2'b10, 4'h0, 1'b0, 1'b0);
        creq(1'b0, 4'h0, 8'h00);
        pulse(2'b01, 4'h0, 1'b0, 1'b0);
        creq(1'b1, 4'h7, 8'h60);
        repeat (20) @(posedge aclk);
        wr(vpi_pkg::OFF_FLAGS, 16'h0001);
        repeat (2) @(posedge aclk);
        creq(1'b1, 4'h6, 8'h61);
        wr(vpi_pkg::OFF_INTCTRL1, 16'h8000);
        ack_on <= 1'b1;
        repeat (6) @(posedge aclk);
        pulse(2'b01, 4'h0, 1'b0, 1'b0);
        creq(1'b0, 4'h0, 8'h00);
    endtask
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = '0;
        {src_event, trap_event, cpu_return, cpu_timed_disable, ack_on} = '0;
        ack_wait = 4'h2;
        err_total = 0;
        total_checks = 0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        test_regs;
        test_service;
        test_mask;
        test_timed;
        tally_and_finish;
    end
    // run bound, some 27 times the expected length
    initial begin
        repeat (5000) @(posedge aclk);
        err_total++;
        tally_and_finish;
    end
endmodule // testbench
`default_nettype wire
